// ### rtl/adcx_cfg.svh
// Constants of the extended control register bank: map, fields, reset values, framing.
// Contract
// - Registers act only in extended control mode.
// - Four-bit address decodes sixteen locations 0h-Fh.
// - Calibration bit starts calibration, never self-clears.
// - Calibration bit ORed with pin; both low first.
// - Phase bit picks 0 or 90 degree DDR.
// - Without demultiplexing, phase bit ignored, 0 degree.
// - Swing bit picks low/high level, resets high.
// - Test pattern bit replaces converted data.
// - First channel powers down by bit or pin.
// - Second channel powers down by bit or pin.
// - Dual-edge bit selects dual-edge sampling.
// - In dual-edge, choice bit selects converted input.
// - Inputs joined only when bits 7:5 are 101b.
// - Time stamp bit enables time stamp feature.
// - Output clock runs unless powered down or reset; the code stops it on clock reset only while demultiplexing.
`ifndef ADCX_CFG_SVH
`define ADCX_CFG_SVH

`define ADCX_ADDR_W 4
`define ADCX_DATA_W 16
`define ADCX_NUM_REGS 16
`define ADCX_FRAME_BITS 5'h18
`define ADCX_HEAD_BITS 5'h08
`define ADCX_CNT_W 5
`define ADCX_SHIFT_W 24
`define ADCX_RD_BIT 23
`define ADCX_ADDR_FIELD 19:16
`define ADCX_HEAD_RD_BIT 7
`define ADCX_HEAD_ADDR 3:0
`define ADCX_DATA_FIELD 15:0
`define ADCX_DATA_MSB 15

`define ADCX_ADDR_CFG 4'h0
`define ADCX_ADDR_RSVD1 4'h1
`define ADCX_ADDR_OFS1 4'h2
`define ADCX_ADDR_FSR1 4'h3
`define ADCX_ADDR_CALADJ 4'h4
`define ADCX_ADDR_OFS2 4'hA
`define ADCX_ADDR_FSR2 4'hB

`define ADCX_RST_CFG 16'h2000
`define ADCX_RST_RSVD1 16'h2A0E
`define ADCX_RST_OFS 16'h0000
`define ADCX_RST_FSR 16'h4000
`define ADCX_RST_CALADJ 16'hDF4B
`define ADCX_RST_OTHER 16'h0000

`define ADCX_BIT_CAL 15
`define ADCX_BIT_PHASE 14
`define ADCX_BIT_SWING 13
`define ADCX_BIT_TPAT 12
`define ADCX_BIT_PD1 11
`define ADCX_BIT_PD2 10
`define ADCX_BIT_LOWRATE 8
`define ADCX_BIT_DES 7
`define ADCX_BIT_INSEL 6
`define ADCX_BIT_TWOS 4
`define ADCX_BIT_TSTAMP 3
`define ADCX_JOIN_FIELD 7:5
`define ADCX_JOIN_CODE 3'h5

`define ADCX_SYNC_W 9
`define ADCX_SYNC_RST 9'h040
`define ADCX_S_XMODE 0
`define ADCX_S_CAL 1
`define ADCX_S_PD1 2
`define ADCX_S_PD2 3
`define ADCX_S_DEMUX 4
`define ADCX_S_DCLKRST 5
`define ADCX_S_CSN 6
`define ADCX_S_SCK 7
`define ADCX_S_SDI 8

`endif

// ### rtl/adcx_pkg.sv
// Types shared by the extended control register bank modules.
package adcx_pkg;
`include "adcx_cfg.svh"

  // Effective controls after mode gating and pin merging.
  typedef struct packed {
    logic phase_90;
    logic swing_high;
    logic test_pattern;
    logic ch1_pd;
    logic ch2_pd;
    logic low_rate;
    logic dual_edge;
    logic des_second;
    logic joined;
    logic twos;
    logic time_stamp;
    logic dclk1_run;
    logic dclk2_run;
    logic cal_request;
  } adcx_ctl_t;

  // Serial frame phase, Gray coded along idle, header, data, done.
  typedef enum logic [1:0] {
    ADCX_IDLE = 2'h0,
    ADCX_HEAD = 2'h1,
    ADCX_DATA = 2'h3,
    ADCX_DONE = 2'h2
  } adcx_phase_t;
endpackage

// ### rtl/adcx_cfg_if.sv
// Carrier between the register bank and its configuration decoder.
`timescale 1ns/1ps
`include "adcx_cfg.svh"
interface adcx_cfg_if;
  import adcx_pkg::*;
  logic [`ADCX_DATA_W-1:0] cfg_word; // Stored configuration word.
  logic xmode; // Extended control mode, synchronised.
  logic demux; // Demultiplexed output mode, synchronised.
  logic cal_pin; // Calibration pin, synchronised.
  logic pd1_pin; // First channel power-down pin.
  logic pd2_pin; // Second channel power-down pin.
  logic oclk_rst; // Output clock reset pin.
  adcx_ctl_t ctl; // Decoded controls.
  modport regs (output cfg_word, xmode, demux, cal_pin, pd1_pin, pd2_pin, oclk_rst, input ctl);
  modport dec (input cfg_word, xmode, demux, cal_pin, pd1_pin, pd2_pin, oclk_rst, output ctl);
endinterface

// ### rtl/adcx_pin_sync.sv
// Two-flop synchronisers for every pin that enters the bank.
`timescale 1ns/1ps
`include "adcx_cfg.svh"
module adcx_pin_sync
  import adcx_pkg::*;
#(
  parameter int W = `ADCX_SYNC_W,
  parameter logic [W-1:0] RST = `ADCX_SYNC_RST
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  // One synchroniser per pin; the first stage feeds only the second.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q; // First stage, may go metastable.
    logic stab_q; // Second stage, safe to read.
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        meta_q <= RST[i];
        stab_q <= RST[i];
      end else begin
        meta_q <= pin_i[i];
        stab_q <= meta_q;
      end
    end
    assign sync_o[i] = stab_q;
  end
endmodule // adcx_pin_sync

// ### rtl/adcx_cfg_decode.sv
// Turns the stored configuration word and control pins into effective controls.
`timescale 1ns/1ps
`include "adcx_cfg.svh"
module adcx_cfg_decode
  import adcx_pkg::*;
(
  adcx_cfg_if.dec cfg
);
  // Outside extended control mode the configuration word is replaced by its reset image.
  wire logic [`ADCX_DATA_W-1:0] eff_w = cfg.xmode ? cfg.cfg_word : `ADCX_RST_CFG;
  wire logic pd1_w = eff_w[`ADCX_BIT_PD1] | cfg.pd1_pin;
  wire logic pd2_w = eff_w[`ADCX_BIT_PD2] | cfg.pd2_pin;
  wire logic des_w = eff_w[`ADCX_BIT_DES];
  // Clock reset only stops the output clocks while demultiplexing.
  wire logic oclk_stop_w = cfg.demux & cfg.oclk_rst;

  assign cfg.ctl.phase_90 = cfg.demux & eff_w[`ADCX_BIT_PHASE];
  assign cfg.ctl.swing_high = eff_w[`ADCX_BIT_SWING];
  assign cfg.ctl.test_pattern = eff_w[`ADCX_BIT_TPAT];
  assign cfg.ctl.ch1_pd = pd1_w;
  assign cfg.ctl.ch2_pd = pd2_w;
  assign cfg.ctl.low_rate = eff_w[`ADCX_BIT_LOWRATE];
  assign cfg.ctl.dual_edge = des_w;
  assign cfg.ctl.des_second = des_w & eff_w[`ADCX_BIT_INSEL];
  assign cfg.ctl.joined = (eff_w[`ADCX_JOIN_FIELD] == `ADCX_JOIN_CODE);
  assign cfg.ctl.twos = eff_w[`ADCX_BIT_TWOS];
  assign cfg.ctl.time_stamp = eff_w[`ADCX_BIT_TSTAMP];
  assign cfg.ctl.dclk1_run = ~pd1_w & ~oclk_stop_w;
  assign cfg.ctl.dclk2_run = ~pd2_w & ~oclk_stop_w;
  // The reset image has the calibration bit low, so only the pin acts in pin mode.
  assign cfg.ctl.cal_request = eff_w[`ADCX_BIT_CAL] | cfg.cal_pin;
endmodule // adcx_cfg_decode

// ### rtl/adcx_ctrl_regs.sv
// Extended control register bank with its serial port and registered control outputs.
`timescale 1ns/1ps
`include "adcx_cfg.svh"
module adcx_ctrl_regs
  import adcx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic extended_control_mode_i,
  input wire logic cal_pin_i,
  input wire logic first_channel_power_down_i,
  input wire logic second_channel_power_down_i,
  input wire logic demux_mode_i,
  input wire logic data_output_clock_reset_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_clk_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic spi_data_oe_o,
  output logic cal_request_o,
  output logic cal_start_o,
  output logic output_clock_phase_select_o,
  output logic output_swing_select_o,
  output logic test_pattern_enable_o,
  output logic first_channel_power_down_o,
  output logic second_channel_power_down_o,
  output logic low_rate_clock_option_o,
  output logic dual_edge_mode_o,
  output logic dual_edge_input_choice_o,
  output logic dual_edge_inputs_joined_o,
  output logic twos_complement_output_o,
  output logic time_stamp_enable_o,
  output logic first_data_output_clock_run_o,
  output logic second_data_output_clock_run_o
);

  // Synchronised pins, all through two flops before use.
  logic [`ADCX_SYNC_W-1:0] pins_w; // Raw pin vector.
  logic [`ADCX_SYNC_W-1:0] sync_w; // Synchronised pin vector.

  assign pins_w[`ADCX_S_XMODE] = extended_control_mode_i;
  assign pins_w[`ADCX_S_CAL] = cal_pin_i;
  assign pins_w[`ADCX_S_PD1] = first_channel_power_down_i;
  assign pins_w[`ADCX_S_PD2] = second_channel_power_down_i;
  assign pins_w[`ADCX_S_DEMUX] = demux_mode_i;
  assign pins_w[`ADCX_S_DCLKRST] = data_output_clock_reset_i;
  assign pins_w[`ADCX_S_CSN] = spi_cs_n_i;
  assign pins_w[`ADCX_S_SCK] = spi_clk_i;
  assign pins_w[`ADCX_S_SDI] = spi_data_i;

  adcx_pin_sync #(
    .W(`ADCX_SYNC_W),
    .RST(`ADCX_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(pins_w),
    .sync_o(sync_w)
  );

  wire logic xmode_s = sync_w[`ADCX_S_XMODE]; // Extended control mode level.
  wire logic demux_s = sync_w[`ADCX_S_DEMUX]; // Demultiplexed output level.
  wire logic pd1_s = sync_w[`ADCX_S_PD1]; // First channel power-down pin.
  wire logic cs_n_s = sync_w[`ADCX_S_CSN]; // Chip select, low during a frame.
  wire logic sck_s = sync_w[`ADCX_S_SCK]; // Serial clock level.
  wire logic sdi_s = sync_w[`ADCX_S_SDI]; // Serial data in.

  // Previous levels of chip select and serial clock, for edge detection.
  logic cs_n_prev_q;
  logic sck_prev_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_n_prev_q <= 1'h1;
      sck_prev_q <= 1'h0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sck_prev_q <= sck_s;
    end
  end

  wire logic cs_act_w = ~cs_n_s; // A frame is open.
  wire logic cs_fall_w = ~cs_n_s & cs_n_prev_q; // Frame opens.
  wire logic cs_rise_w = cs_n_s & ~cs_n_prev_q; // Frame closes.
  wire logic sck_rise_w = sck_s & ~sck_prev_q & cs_act_w; // Sample edge.
  wire logic sck_fall_w = ~sck_s & sck_prev_q & cs_act_w; // Launch edge.

  // Frame state: bit counter, receive shifter, phase and overrun flag.
  logic [`ADCX_CNT_W-1:0] cnt_q;
  logic [`ADCX_SHIFT_W-1:0] shift_q;
  adcx_phase_t phase_q;
  logic over_q; // More clocks than a frame holds arrived.

  wire logic [`ADCX_CNT_W-1:0] cnt_inc_w = cnt_q + `ADCX_CNT_W'(1);
  wire logic take_bit_w = sck_rise_w & (phase_q != ADCX_DONE) & (phase_q != ADCX_IDLE);

  // Next phase after a sampled bit; header gives way to data after eight bits.
  adcx_phase_t phase_step_w;
  assign phase_step_w = (cnt_inc_w == `ADCX_FRAME_BITS) ? ADCX_DONE :
                        (cnt_inc_w == `ADCX_HEAD_BITS) ? ADCX_DATA : phase_q;

  // Receive shifter and framing; a new chip select always restarts the count.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      shift_q <= '0;
      phase_q <= ADCX_IDLE;
      over_q <= 1'h0;
    end else if (cs_fall_w) begin
      cnt_q <= '0;
      phase_q <= ADCX_HEAD;
      over_q <= 1'h0;
    end else if (cs_rise_w) begin
      phase_q <= ADCX_IDLE;
    end else if (take_bit_w) begin
      shift_q <= {shift_q[`ADCX_SHIFT_W-2:0], sdi_s};
      cnt_q <= cnt_inc_w;
      phase_q <= phase_step_w;
    end else if (sck_rise_w && phase_q == ADCX_DONE) begin
      over_q <= 1'h1;
    end
  end

  // A write lands only at frame close after exactly a full frame.
  wire logic commit_w = cs_rise_w & (phase_q == ADCX_DONE) & ~over_q &
                        ~shift_q[`ADCX_RD_BIT];
  wire logic [`ADCX_ADDR_W-1:0] wr_addr_w = shift_q[`ADCX_ADDR_FIELD];
  wire logic [`ADCX_DATA_W-1:0] wr_data_w = shift_q[`ADCX_DATA_FIELD];

  // Reset image of each location; the table is a constant, not a file.
  function automatic logic [`ADCX_DATA_W-1:0] reset_value(input logic [`ADCX_ADDR_W-1:0] a);
    logic [`ADCX_DATA_W-1:0] v;
    v = `ADCX_RST_OTHER;
    case (a)
      `ADCX_ADDR_CFG: v = `ADCX_RST_CFG;
      `ADCX_ADDR_RSVD1: v = `ADCX_RST_RSVD1;
      `ADCX_ADDR_OFS1, `ADCX_ADDR_OFS2: v = `ADCX_RST_OFS;
      `ADCX_ADDR_FSR1, `ADCX_ADDR_FSR2: v = `ADCX_RST_FSR;
      `ADCX_ADDR_CALADJ: v = `ADCX_RST_CALADJ;
      default: v = `ADCX_RST_OTHER;
    endcase
    return v;
  endfunction

  // Sixteen storage words; reserved slots hold what the host writes.
  logic [`ADCX_DATA_W-1:0] regs_q [`ADCX_NUM_REGS];

  // One decoder per location of the four-bit address space.
  for (genvar r = 0; r < `ADCX_NUM_REGS; r++) begin : g_reg
    wire logic hit_w = commit_w & (wr_addr_w == `ADCX_ADDR_W'(r));
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        regs_q[r] <= reset_value(`ADCX_ADDR_W'(r));
      end else if (hit_w) begin
        regs_q[r] <= wr_data_w;
      end
    end
  end

  // Read path: the word is caught once the header is in, then shifted out.
  logic [`ADCX_DATA_W-1:0] out_q; // Outgoing read word.
  logic loaded_q; // Read word captured for this frame.
  logic rd_mode_q; // Current frame is a read.
  logic sdo_q;
  logic sdo_oe_q;

  wire logic rd_load_w = (phase_q == ADCX_DATA) & (cnt_q == `ADCX_HEAD_BITS) & ~loaded_q;
  wire logic rd_bit_w = shift_q[`ADCX_HEAD_RD_BIT];
  wire logic [`ADCX_ADDR_W-1:0] rd_addr_w = shift_q[`ADCX_HEAD_ADDR];

  // Data changes on the falling serial clock so the host samples it on the rise.
  always_ff @(posedge clk_i) begin
    if (reset_i || cs_fall_w) begin
      out_q <= '0;
      loaded_q <= 1'h0;
      rd_mode_q <= 1'h0;
      sdo_q <= 1'h0;
    end else if (rd_load_w) begin
      out_q <= regs_q[rd_addr_w];
      loaded_q <= 1'h1;
      rd_mode_q <= rd_bit_w;
    end else if (sck_fall_w && rd_mode_q) begin
      sdo_q <= out_q[`ADCX_DATA_MSB];
      out_q <= {out_q[`ADCX_DATA_MSB-1:0], 1'h0};
    end
  end

  // The data pin is driven inside an open read frame, and for one cycle when the frame after a read opens.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sdo_oe_q <= 1'h0;
    end else begin
      sdo_oe_q <= cs_act_w & rd_mode_q;
    end
  end

  assign spi_data_o = sdo_q;
  assign spi_data_oe_o = sdo_oe_q;

  // Configuration decoder over the carrier interface.
  adcx_cfg_if u_cfg_if ();

  assign u_cfg_if.cfg_word = regs_q[`ADCX_ADDR_CFG];
  assign u_cfg_if.xmode = xmode_s;
  assign u_cfg_if.demux = demux_s;
  assign u_cfg_if.cal_pin = sync_w[`ADCX_S_CAL];
  assign u_cfg_if.pd1_pin = pd1_s;
  assign u_cfg_if.pd2_pin = sync_w[`ADCX_S_PD2];
  assign u_cfg_if.oclk_rst = sync_w[`ADCX_S_DCLKRST];

  adcx_cfg_decode u_dec (
    .cfg(u_cfg_if.dec)
  );

  // Registered controls; reset shows the pin-mode image (high swing, clocks running).
  adcx_ctl_t ctl_q;
  logic cal_start_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctl_q <= '0;
      ctl_q.swing_high <= 1'h1;
      ctl_q.dclk1_run <= 1'h1;
      ctl_q.dclk2_run <= 1'h1;
      cal_start_q <= 1'h0;
    end else begin
      ctl_q <= u_cfg_if.ctl;
      // Only a low-to-high change of the merged request launches a run.
      cal_start_q <= u_cfg_if.ctl.cal_request & ~ctl_q.cal_request;
    end
  end

  assign cal_request_o = ctl_q.cal_request;
  assign cal_start_o = cal_start_q;
  assign output_clock_phase_select_o = ctl_q.phase_90;
  assign output_swing_select_o = ctl_q.swing_high;
  assign test_pattern_enable_o = ctl_q.test_pattern;
  assign first_channel_power_down_o = ctl_q.ch1_pd;
  assign second_channel_power_down_o = ctl_q.ch2_pd;
  assign low_rate_clock_option_o = ctl_q.low_rate;
  assign dual_edge_mode_o = ctl_q.dual_edge;
  assign dual_edge_input_choice_o = ctl_q.des_second;
  assign dual_edge_inputs_joined_o = ctl_q.joined;
  assign twos_complement_output_o = ctl_q.twos;
  assign time_stamp_enable_o = ctl_q.time_stamp;
  assign first_data_output_clock_run_o = ctl_q.dclk1_run;
  assign second_data_output_clock_run_o = ctl_q.dclk2_run;

  // Checks on the bank's own behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  wire logic [`ADCX_DATA_W-1:0] cfg_w = regs_q[`ADCX_ADDR_CFG];

  sequence s_cfg_commit;
    commit_w && wr_addr_w == `ADCX_ADDR_CFG;
  endsequence

  sequence s_req_rise;
    !u_cfg_if.ctl.cal_request ##1 u_cfg_if.ctl.cal_request;
  endsequence

  chk_write_commit: assert property (
    s_cfg_commit |=> cfg_w == $past(wr_data_w))
    else $error("Full write frame did not update configuration.");

  chk_partial_frame: assert property (
    cs_rise_w && (phase_q != ADCX_DONE || over_q) |=> $stable(cfg_w))
    else $error("Partial frame changed configuration.");

  chk_cal_holds: assert property (
    cfg_w[`ADCX_BIT_CAL] && !commit_w |=> cfg_w[`ADCX_BIT_CAL])
    else $error("Calibration bit cleared without a write.");

  chk_cal_edge_start: assert property (
    s_req_rise |=> cal_start_o ##1 !cal_start_o)
    else $error("Calibration start not a single pulse on request rise.");

  chk_pin_mode_idle: assert property (
    !xmode_s && !pd1_s |=> !test_pattern_enable_o && output_swing_select_o
                         && !first_channel_power_down_o)
    else $error("Register contents acted in pin control mode.");

  chk_phase_nondemux: assert property (
    !demux_s |=> !output_clock_phase_select_o)
    else $error("Phase select acted without demultiplexing.");

  chk_phase_select: assert property (
    xmode_s && demux_s |=> output_clock_phase_select_o == $past(cfg_w[`ADCX_BIT_PHASE]))
    else $error("Phase select does not follow its bit.");

  chk_pd_pin_clock: assert property (
    pd1_s |=> first_channel_power_down_o && !first_data_output_clock_run_o)
    else $error("Power-down pin did not stop the first channel.");

  chk_join_pattern: assert property (
    dual_edge_inputs_joined_o |-> dual_edge_mode_o && !dual_edge_input_choice_o)
    else $error("Inputs joined outside the 101b setting.");

  chk_swing_follow: assert property (
    xmode_s |=> output_swing_select_o == $past(cfg_w[`ADCX_BIT_SWING]))
    else $error("Swing select does not follow its bit.");

  chk_read_drive: assert property (
    spi_data_oe_o |-> $past(rd_mode_q) && $past(cs_act_w))
    else $error("Data pin driven outside a read frame.");

  // Output clocks stop while demultiplexing with the clock reset pin high.
  sequence s_clock_hold;
    demux_s && sync_w[`ADCX_S_DCLKRST];
  endsequence

  chk_clock_stop: assert property (
    s_clock_hold |=> !first_data_output_clock_run_o && !second_data_output_clock_run_o)
    else $error("Output clocks ran during clock reset.");

  chk_other_addr: assert property (
    commit_w && wr_addr_w != `ADCX_ADDR_CFG |=> $stable(cfg_w))
    else $error("Write to another address changed configuration.");

  // Field checks: in extended mode each control follows its bits one cycle later, second power-down ORed with its pin.
  // The lag is the output register that keeps every top output on a flip-flop.
  chk_test_pattern: assert property (
    xmode_s |=> test_pattern_enable_o == $past(cfg_w[`ADCX_BIT_TPAT]))
    else $error("Test pattern does not follow its bit.");

  chk_pd2_merge: assert property (
    xmode_s |=> second_channel_power_down_o ==
                ($past(cfg_w[`ADCX_BIT_PD2]) | $past(sync_w[`ADCX_S_PD2])))
    else $error("Second channel power-down does not merge bit and pin.");

  chk_dual_edge_sel: assert property (
    xmode_s |=> dual_edge_mode_o == $past(cfg_w[`ADCX_BIT_DES]))
    else $error("Dual-edge mode does not follow its bit.");

  chk_input_choice: assert property (
    xmode_s |=> dual_edge_input_choice_o ==
                $past(cfg_w[`ADCX_BIT_DES] & cfg_w[`ADCX_BIT_INSEL]))
    else $error("Input choice does not follow its bits.");

  chk_twos_format: assert property (
    xmode_s |=> twos_complement_output_o == $past(cfg_w[`ADCX_BIT_TWOS]))
    else $error("Output format does not follow its bit.");

  chk_time_stamp: assert property (
    xmode_s |=> time_stamp_enable_o == $past(cfg_w[`ADCX_BIT_TSTAMP]))
    else $error("Time stamp enable does not follow its bit.");

endmodule // adcx_ctrl_regs

// ### tb/adcx_host_model.sv
// Behavioural serial host that frames writes and reads toward the register bank.
`timescale 1ns/1ps
module adcx_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [23:0] frame_i,
  input wire logic [4:0] rises_i,
  input wire logic [3:0] half_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  output logic [15:0] rdata_o,
  output logic busy_o
);
  int i; // Bit counter within a frame.
  // One frame per go pulse; half_i sets a prompt or a slow serial clock.
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    rdata_o = 16'h0000;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      // Outside a frame the data line toggles every clock, so it never holds a stale bit.
      sdi_o <= ~sdi_o;
      if (go_i) begin
        busy_o <= 1'b1;
        cs_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        // A rise count other than 24 is how scenarios make a malformed frame.
        for (i = 0; i < rises_i; i++) begin
          sdi_o <= frame_i[23 - (i % 24)];
          repeat (half_i) @(posedge clk_i);
          rdata_o <= {rdata_o[14:0], sdo_i};
          sck_o <= 1'b1;
          repeat (half_i) @(posedge clk_i);
          sck_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule // adcx_host_model

// ### tb/tb_adcx_ctrl_regs.sv
// Self-checking bench for the extended control register bank.
`timescale 1ns/1ps
module tb_adcx_ctrl_regs;
  import adcx_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] pins = 6'h00; // Mode, calibration, two power-downs, demux, clock reset.
  logic cs_n, sck, sdi, sdo, oe, busy, cal_start;
  logic tgl = 1'b0; // Level seen by the host while the device does not drive.
  logic go = 1'b0;
  logic [23:0] frame = 24'h000000;
  logic [4:0] rises = 5'h18;
  logic [3:0] half = 4'h6;
  logic [15:0] rdata, got;
  logic [13:0] outs; // All control outputs except the start pulse, calibration request first.
  logic [15:0] shadow [16]; // Expected register contents.
  logic [31:0] seed = 32'h000093BE;
  logic [31:0] r;
  logic [3:0] a;
  logic [15:0] w;
  int n_fail = 0;
  int comparisons = 0;
  int pulses = 0;
  int p0;

  always #2 clk_i = ~clk_i;

  // Counts calibration launches and keeps the released data line moving.
  always @(posedge clk_i) begin
    tgl <= ~tgl;
    if (cal_start === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  adcx_ctrl_regs dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .extended_control_mode_i(pins[5]), .cal_pin_i(pins[4]),
    .first_channel_power_down_i(pins[3]), .second_channel_power_down_i(pins[2]),
    .demux_mode_i(pins[1]), .data_output_clock_reset_i(pins[0]),
    .spi_cs_n_i(cs_n), .spi_clk_i(sck), .spi_data_i(sdi),
    .spi_data_o(sdo), .spi_data_oe_o(oe),
    .cal_request_o(outs[13]), .cal_start_o(cal_start),
    .output_clock_phase_select_o(outs[12]), .output_swing_select_o(outs[11]),
    .test_pattern_enable_o(outs[10]), .first_channel_power_down_o(outs[9]),
    .second_channel_power_down_o(outs[8]), .low_rate_clock_option_o(outs[7]),
    .dual_edge_mode_o(outs[6]), .dual_edge_input_choice_o(outs[5]),
    .dual_edge_inputs_joined_o(outs[4]), .twos_complement_output_o(outs[3]),
    .time_stamp_enable_o(outs[2]), .first_data_output_clock_run_o(outs[1]),
    .second_data_output_clock_run_o(outs[0])
  );

  // The host reads the wire, which carries the device only while it drives.
  adcx_host_model host (
    .clk_i(clk_i), .go_i(go), .frame_i(frame), .rises_i(rises), .half_i(half),
    .sdo_i(oe === 1'b1 ? sdo : tgl), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
    .rdata_o(rdata), .busy_o(busy)
  );

  // Xorshift source, fixed seed so every run repeats.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reset image of each location.
  function automatic logic [15:0] rst_val(input logic [3:0] ad);
    case (ad)
      4'h0: return 16'h2000;
      4'h1: return 16'h2A0E;
      4'h3, 4'hB: return 16'h4000;
      4'h4: return 16'hDF4B;
      default: return 16'h0000;
    endcase
  endfunction

  // Expected control outputs for a configuration word and the pins.
  function automatic logic [13:0] exp_out(input logic [15:0] cw, input logic [5:0] p);
    logic [15:0] e;
    logic d1, d2, st;
    e = p[5] ? cw : 16'h2000;
    d1 = e[11] | p[3];
    d2 = e[10] | p[2];
    st = p[1] & p[0];
    return {e[15] | p[4], p[1] & e[14], e[13], e[12], d1, d2, e[8], e[7],
      e[7] & e[6], e[7:5] == 3'h5, e[4], e[3], ~d1 & ~st, ~d2 & ~st};
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: register got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_ctl(input logic [13:0] g, input logic [13:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: controls got %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input int g, input int e);
    comparisons++;
    if (g != e) begin
      n_fail++;
      $display("wrong value at %0t: launches got %0d expected %0d", $time, g, e);
    end
  endtask

  // One frame, waited for under a bound so a hang ends the run.
  task automatic xfer(input logic [23:0] f, input logic [4:0] n);
    int k;
    frame <= f;
    rises <= n;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      n_fail++;
      $display("wrong value at %0t: serial frame never ended", $time);
      end_of_test();
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d, input logic [4:0] n);
    xfer({4'h0, ad, d}, n);
  endtask

  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    xfer({4'h8, ad, 16'h0000}, 5'h18);
    d = rdata;
  endtask

  // Main sequence: reset images, random traffic, malformed frames, calibration.
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_ctl(outs, exp_out(16'h2000, 6'h00));
    pins <= 6'h20;
    for (int i = 0; i < 16; i++) begin
      shadow[i] = rst_val(4'(i));
      rd(4'(i), got);
      chk_word(got, shadow[i]);
    end
    // Corner words first (joined and non-joined dual edge, all control bits), then random.
    for (int i = 0; i < 28; i++) begin
      r = xs();
      a = (i < 8) ? 4'h0 : r[3:0];
      w = (i == 0) ? 16'h00A0 : (i == 1) ? 16'h00E0 : (i == 2) ? 16'hFDF8 : r[31:16];
      if (a == 4'h0) begin
        w = w & 16'hFDF8;
      end
      half <= r[4] ? 4'h9 : 4'h6;
      pins <= {1'b1, r[9:5]};
      wr(a, w, 5'h18);
      shadow[a] = w;
      rd(a, got);
      chk_word(got, shadow[a]);
      pins <= r[15:10];
      repeat (6) @(posedge clk_i);
      chk_ctl(outs, exp_out(shadow[0], r[15:10]));
    end
    // Frames one rise short or long must leave the register alone.
    pins <= 6'h20;
    wr(4'h2, ~shadow[2], 5'h17);
    wr(4'h2, ~shadow[2], 5'h19);
    rd(4'h2, got);
    chk_word(got, shadow[2]);
    // Calibration: both sources low first, then one launch per 0 to 1 edge.
    wr(4'h0, 16'h2000, 5'h18);
    p0 = pulses;
    wr(4'h0, 16'hA000, 5'h18);
    wr(4'h0, 16'hA000, 5'h18);
    pins <= 6'h30;
    repeat (6) @(posedge clk_i);
    chk_cnt(pulses - p0, 1);
    rd(4'h0, got);
    chk_word(got, 16'hA000);
    pins <= 6'h20;
    wr(4'h0, 16'h2000, 5'h18);
    wr(4'h0, 16'hA000, 5'h18);
    repeat (2) @(posedge clk_i);
    chk_cnt(pulses - p0, 2);
    end_of_test();
  end
endmodule // tb_adcx_ctrl_regs
